// >>> uhm_defs.vh
// field positions, opcodes and reserved values for the halving/long multiply unit
`ifndef UHM_DEFS_VH
`define UHM_DEFS_VH

// first halfword of the encoding sits in bits 31:16, second in 15:0
`define UHM_HW1_MSB 31
`define UHM_HW1_LSB 16
`define UHM_HW2_MSB 15
`define UHM_HW2_LSB 0

// register index fields inside the 32-bit encoding
`define UHM_FIRST_SRC_MSB 19
`define UHM_FIRST_SRC_LSB 16
`define UHM_HALF_DEST_MSB 11
`define UHM_HALF_DEST_LSB 8
`define UHM_LOW_DEST_MSB  15
`define UHM_LOW_DEST_LSB  12
`define UHM_HIGH_DEST_MSB 11
`define UHM_HIGH_DEST_LSB 8
`define UHM_SECOND_SRC_MSB 3
`define UHM_SECOND_SRC_LSB 0

// opcode prefix: top twelve bits of the first halfword
`define UHM_PFX_MSB 31
`define UHM_PFX_LSB 20
`define UHM_PFX_HSAX   12'hfae
`define UHM_PFX_HSUB16 12'hfad
`define UHM_PFX_HSUB8  12'hfac
`define UHM_PFX_MDAL   12'hfbe
`define UHM_PFX_MULL   12'hfba

// second halfword sub-fields
`define UHM_SUB_MSB 7
`define UHM_SUB_LSB 4
`define UHM_SUB_DSP   4'h6
`define UHM_SUB_MAIN  4'h0
`define UHM_ONES_MSB 15
`define UHM_ONES_LSB 12
`define UHM_ONES_VAL 4'hf

// register indices that make an encoding unpredictable
`define UHM_IDX_SP 4'hd
`define UHM_IDX_PC 4'hf

// reset values
`define UHM_RST_DATA 32'h0000_0000
`define UHM_RST_IDX  4'h0

`endif

// >>> uhm_half_lane.v
// one lane of a halving add or subtract, result is bits w:1 of the sum or difference
`timescale 1ns/10ps
module uhm_half_lane #(
  parameter W = 16
) (
  // operands
  input  wire [W-1:0] lane_a,
  input  wire [W-1:0] lane_b,
  input  wire         lane_sub,
  // halved result
  output wire [W-1:0] lane_y
);

  wire [W:0] ext_a;
  wire [W:0] ext_b;
  wire [W:0] full;

  assign ext_a = {1'b0, lane_a};
  assign ext_b = {1'b0, lane_b};
  // bit w of a difference is its sign, so w:1 is the true halved value
  assign full = lane_sub ? (ext_a - ext_b) : (ext_a + ext_b);
  assign lane_y = full[W:1];

endmodule

// >>> uhm_mul_acc.v
// unsigned 32x32 multiply plus a 64-bit and a 32-bit addend
`timescale 1ns/10ps
module uhm_mul_acc (
  // factors
  input  wire [31:0] mul_a,
  input  wire [31:0] mul_b,
  // addends
  input  wire [63:0] acc_wide,
  input  wire [31:0] acc_word,
  // result, wraps modulo 2^64
  output wire [63:0] mul_y
);

  wire [63:0] prod;

  assign prod  = mul_a * mul_b;
  assign mul_y = prod + acc_wide + {32'h0000_0000, acc_word};

endmodule

// >>> uhm_exec.v
// execution stage for unsigned halving subtracts and long multiplies
`timescale 1ns/10ps
`include "uhm_defs.vh"
module uhm_exec (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rstn,
  // issued instruction
  input  wire        issue_valid,
  input  wire [31:0] issue_instr,
  input  wire        issue_cond_pass,
  // implemented extensions
  input  wire        signal_processing_extension_present,
  input  wire        main_extension_present,
  // operand values read by the core at the encoded indices
  input  wire [31:0] first_source_data,
  input  wire [31:0] second_source_data,
  input  wire [31:0] high_dest_data,
  input  wire [31:0] low_dest_data,
  // status of the retired instruction
  output reg         done_q,
  output reg         undef_q,
  output reg         unpred_q,
  output reg         flags_we_q,
  // low or single destination write port
  output reg         wb_lo_en_q,
  output reg  [3:0]  wb_lo_index_q,
  output reg  [31:0] wb_lo_data_q,
  // high destination write port
  output reg         wb_hi_en_q,
  output reg  [3:0]  wb_hi_index_q,
  output reg  [31:0] wb_hi_data_q
);

  // ===========================================================
  // operation codes
  // ===========================================================
  localparam [5:0] OP_NONE = 6'b000000;
  localparam [5:0] OP_HSAX = 6'b000001;
  localparam [5:0] OP_HS16 = 6'b000010;
  localparam [5:0] OP_HS8  = 6'b000100;
  localparam [5:0] OP_MDAL = 6'b001000;
  localparam [5:0] OP_MLAL = 6'b010000;
  localparam [5:0] OP_MULL = 6'b100000;

  // ===========================================================
  // field extraction
  // ===========================================================
  wire [11:0] pfx;
  wire [3:0]  sub;
  wire [3:0]  ones;
  wire [3:0]  first_source_index;
  wire [3:0]  second_source_index;
  wire [3:0]  half_dest_index;
  wire [3:0]  low_destination_index;
  wire [3:0]  high_destination_index;

  assign pfx  = issue_instr[`UHM_PFX_MSB:`UHM_PFX_LSB];
  assign sub  = issue_instr[`UHM_SUB_MSB:`UHM_SUB_LSB];
  assign ones = issue_instr[`UHM_ONES_MSB:`UHM_ONES_LSB];
  assign first_source_index =
    issue_instr[`UHM_FIRST_SRC_MSB:`UHM_FIRST_SRC_LSB];
  assign second_source_index =
    issue_instr[`UHM_SECOND_SRC_MSB:`UHM_SECOND_SRC_LSB];
  assign half_dest_index =
    issue_instr[`UHM_HALF_DEST_MSB:`UHM_HALF_DEST_LSB];
  assign low_destination_index =
    issue_instr[`UHM_LOW_DEST_MSB:`UHM_LOW_DEST_LSB];
  assign high_destination_index =
    issue_instr[`UHM_HIGH_DEST_MSB:`UHM_HIGH_DEST_LSB];

  // ===========================================================
  // opcode decode
  // ===========================================================
  reg [5:0] op_sel;

  always @* begin
    op_sel = OP_NONE;
    if (pfx == `UHM_PFX_HSAX && ones == `UHM_ONES_VAL &&
        sub == `UHM_SUB_DSP) begin
      op_sel = OP_HSAX;
    end else if (pfx == `UHM_PFX_HSUB16 && ones == `UHM_ONES_VAL &&
                 sub == `UHM_SUB_DSP) begin
      op_sel = OP_HS16;
    end else if (pfx == `UHM_PFX_HSUB8 && ones == `UHM_ONES_VAL &&
                 sub == `UHM_SUB_DSP) begin
      op_sel = OP_HS8;
    end else if (pfx == `UHM_PFX_MDAL && sub == `UHM_SUB_DSP) begin
      op_sel = OP_MDAL;
    end else if (pfx == `UHM_PFX_MDAL && sub == `UHM_SUB_MAIN) begin
      op_sel = OP_MLAL;
    end else if (pfx == `UHM_PFX_MULL && sub == `UHM_SUB_MAIN) begin
      op_sel = OP_MULL;
    end
  end

  wire is_halving;
  wire is_long;

  assign is_halving = |(op_sel & (OP_HSAX | OP_HS16 | OP_HS8));
  assign is_long    = |(op_sel & (OP_MDAL | OP_MLAL | OP_MULL));

  // ===========================================================
  // undefined and unpredictable checks
  // ===========================================================
  wire need_dsp;
  wire need_main;
  wire undef_hit;
  wire fs_bad;
  wire ss_bad;
  wire hd_bad;
  wire lo_bad;
  wire hi_bad;
  wire unpred_half;
  wire unpred_long;
  wire unpred_hit;

  assign need_dsp  = is_halving || (op_sel == OP_MDAL);
  assign need_main = (op_sel == OP_MLAL) || (op_sel == OP_MULL);
  assign undef_hit =
    (need_dsp && !signal_processing_extension_present) ||
    (need_main && !main_extension_present);

  assign fs_bad = (first_source_index == `UHM_IDX_SP) ||
                  (first_source_index == `UHM_IDX_PC);
  assign ss_bad = (second_source_index == `UHM_IDX_SP) ||
                  (second_source_index == `UHM_IDX_PC);
  assign hd_bad = (half_dest_index == `UHM_IDX_SP) ||
                  (half_dest_index == `UHM_IDX_PC);
  assign lo_bad = (low_destination_index == `UHM_IDX_SP) ||
                  (low_destination_index == `UHM_IDX_PC);
  assign hi_bad = (high_destination_index == `UHM_IDX_SP) ||
                  (high_destination_index == `UHM_IDX_PC);

  assign unpred_half = is_halving && (hd_bad || fs_bad || ss_bad);
  assign unpred_long = is_long &&
    (lo_bad || hi_bad || fs_bad || ss_bad ||
     (low_destination_index == high_destination_index));
  assign unpred_hit  = unpred_half || unpred_long;

  // ===========================================================
  // halving lanes
  // ===========================================================
  wire [31:0] hs8_y;
  wire [31:0] hs16_y;
  wire [31:0] hsax_y;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
      uhm_half_lane #(.W(8)) u_lane (
        .lane_a   (first_source_data[8*gi+7:8*gi]),
        .lane_b   (second_source_data[8*gi+7:8*gi]),
        .lane_sub (1'b1),
        .lane_y   (hs8_y[8*gi+7:8*gi])
      );
    end
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_half
      uhm_half_lane #(.W(16)) u_lane (
        .lane_a   (first_source_data[16*gi+15:16*gi]),
        .lane_b   (second_source_data[16*gi+15:16*gi]),
        .lane_sub (1'b1),
        .lane_y   (hs16_y[16*gi+15:16*gi])
      );
    end
  endgenerate

  // exchange form: second operand halves swapped, low adds, high subtracts
  uhm_half_lane #(.W(16)) u_sax_lo (
    .lane_a   (first_source_data[15:0]),
    .lane_b   (second_source_data[31:16]),
    .lane_sub (1'b0),
    .lane_y   (hsax_y[15:0])
  );

  uhm_half_lane #(.W(16)) u_sax_hi (
    .lane_a   (first_source_data[31:16]),
    .lane_b   (second_source_data[15:0]),
    .lane_sub (1'b1),
    .lane_y   (hsax_y[31:16])
  );

  // ===========================================================
  // long multiply
  // ===========================================================
  reg  [63:0] acc_wide;
  reg  [31:0] acc_word;
  wire [63:0] mul_y;

  always @* begin
    acc_wide = 64'h0000_0000_0000_0000;
    acc_word = 32'h0000_0000;
    case (op_sel)
      OP_MDAL: begin
        acc_wide = {32'h0000_0000, high_dest_data};
        acc_word = low_dest_data;
      end
      OP_MLAL: begin
        acc_wide = {high_dest_data, low_dest_data};
      end
      default: begin
        acc_wide = 64'h0000_0000_0000_0000;
        acc_word = 32'h0000_0000;
      end
    endcase
  end

  uhm_mul_acc u_mul (
    .mul_a    (first_source_data),
    .mul_b    (second_source_data),
    .acc_wide (acc_wide),
    .acc_word (acc_word),
    .mul_y    (mul_y)
  );

  // ===========================================================
  // result select
  // ===========================================================
  reg [31:0] half_y;

  always @* begin
    case (op_sel)
      OP_HSAX: half_y = hsax_y;
      OP_HS16: half_y = hs16_y;
      OP_HS8:  half_y = hs8_y;
      default: half_y = `UHM_RST_DATA;
    endcase
  end

  // ===========================================================
  // retire and writeback
  // ===========================================================
  wire take;
  wire exec_ok;

  assign take    = issue_valid && (op_sel != OP_NONE);
  // an undefined or unpredictable encoding is refused without any write
  assign exec_ok = take && !undef_hit && !unpred_hit && issue_cond_pass;

  // ===========================================================
  // next writeback values
  // ===========================================================
  reg  [3:0]  wb_lo_index_d;
  reg  [31:0] wb_lo_data_d;
  reg  [3:0]  wb_hi_index_d;
  reg  [31:0] wb_hi_data_d;

  // index and data hold between enabled writes
  always @* begin
    wb_lo_index_d = wb_lo_index_q;
    wb_lo_data_d  = wb_lo_data_q;
    wb_hi_index_d = wb_hi_index_q;
    wb_hi_data_d  = wb_hi_data_q;
    if (exec_ok && is_halving) begin
      wb_lo_index_d = half_dest_index;
      wb_lo_data_d  = half_y;
    end
    if (exec_ok && is_long) begin
      wb_lo_index_d = low_destination_index;
      wb_lo_data_d  = mul_y[31:0];
      wb_hi_index_d = high_destination_index;
      wb_hi_data_d  = mul_y[63:32];
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_q        <= 1'b0;
      undef_q       <= 1'b0;
      unpred_q      <= 1'b0;
      flags_we_q    <= 1'b0;
      wb_lo_en_q    <= 1'b0;
      wb_lo_index_q <= `UHM_RST_IDX;
      wb_lo_data_q  <= `UHM_RST_DATA;
      wb_hi_en_q    <= 1'b0;
      wb_hi_index_q <= `UHM_RST_IDX;
      wb_hi_data_q  <= `UHM_RST_DATA;
    end else begin
      done_q     <= take;
      undef_q    <= take && undef_hit;
      unpred_q   <= take && !undef_hit && unpred_hit;
      flags_we_q <= 1'b0;
      wb_lo_en_q <= exec_ok;
      wb_hi_en_q <= exec_ok && is_long;
      wb_lo_index_q <= wb_lo_index_d;
      wb_lo_data_q  <= wb_lo_data_d;
      wb_hi_index_q <= wb_hi_index_d;
      wb_hi_data_q  <= wb_hi_data_d;
    end
  end

endmodule

// >>> uhm_exec_checker.sv
// assertion checker for the halving subtract and long multiply unit
`timescale 1ns/10ps
`include "uhm_defs.vh"
module uhm_exec_checker (
  // clock and reset
  input wire        sys_clk,
  input wire        rstn,
  // issue side
  input wire        issue_valid,
  input wire [31:0] issue_instr,
  input wire        issue_cond_pass,
  input wire        signal_processing_extension_present,
  input wire        main_extension_present,
  input wire [31:0] first_source_data,
  input wire [31:0] second_source_data,
  // results
  input wire        undef_q,
  input wire        unpred_q,
  input wire        flags_we_q,
  input wire        wb_lo_en_q,
  input wire [3:0]  wb_lo_index_q,
  input wire [31:0] wb_lo_data_q,
  input wire        wb_hi_en_q,
  input wire [3:0]  wb_hi_index_q,
  input wire [31:0] wb_hi_data_q
);
  // ==========================================================
  // decode helpers
  wire [11:0] pf = issue_instr[31:20];
  wire [3:0]  sb = issue_instr[7:4];
  wire [3:0]  fi = issue_instr[19:16];
  wire [3:0]  rl = issue_instr[15:12];
  wire [3:0]  rh = issue_instr[11:8];
  wire [3:0]  si = issue_instr[3:0];
  wire        dsp = signal_processing_extension_present;
  wire        mx = main_extension_present;
  // x|2 equals f only for indices 13 and 15
  wire bh = (fi|4'h2)==4'hf || (rh|4'h2)==4'hf || (si|4'h2)==4'hf;
  wire bl = bh || (rl|4'h2)==4'hf || rl==rh;
  wire hv = issue_valid && rl==4'hf && sb==4'h6 && (pf==`UHM_PFX_HSAX
            || pf==`UHM_PFX_HSUB16 || pf==`UHM_PFX_HSUB8);
  wire md = issue_valid && pf==`UHM_PFX_MDAL && sb==4'h6;
  wire lm = issue_valid && sb==4'h0
            && (pf==`UHM_PFX_MDAL || pf==`UHM_PFX_MULL);
  wire ml = lm && pf==`UHM_PFX_MULL;
  wire [63:0] prod = {32'h0, first_source_data}
                     * {32'h0, second_source_data};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // properties
  a_no_flag_write: assert property (
    flags_we_q == 1'b0) else $error("flag write seen");
  a_cond_fail_quiet: assert property (
    issue_valid && !issue_cond_pass |=> !wb_lo_en_q && !wb_hi_en_q)
    else $error("write after failed condition");
  a_dsp_absent: assert property (
    (hv || md) && !dsp |=> undef_q && !wb_lo_en_q && !wb_hi_en_q)
    else $error("missing undefined without dsp");
  a_main_absent: assert property (
    lm && !mx |=> undef_q && !wb_lo_en_q && !wb_hi_en_q)
    else $error("missing undefined without main");
  a_half_unpred: assert property (
    hv && dsp && bh |=> unpred_q && !undef_q && !wb_lo_en_q)
    else $error("halving index not refused");
  a_long_unpred: assert property (
    (lm && mx || md && dsp) && bl |=> unpred_q && !wb_hi_en_q)
    else $error("long index not refused");
  a_half_dest: assert property (
    hv && dsp && !bh && issue_cond_pass |=> wb_lo_en_q
    && !wb_hi_en_q && wb_lo_index_q == $past(rh))
    else $error("halving destination wrong");
  a_mul_result: assert property (
    ml && mx && !bl && issue_cond_pass |=> wb_hi_en_q && wb_lo_en_q
    && {wb_hi_data_q, wb_lo_data_q} == $past(prod)
    && wb_hi_index_q == $past(rh) && wb_lo_index_q == $past(rl))
    else $error("long product wrong");
endmodule

bind uhm_exec uhm_exec_checker chk_u (.sys_clk, .rstn, .issue_valid,
  .issue_instr, .issue_cond_pass, .signal_processing_extension_present,
  .main_extension_present, .first_source_data, .second_source_data,
  .undef_q, .unpred_q, .flags_we_q, .wb_lo_en_q, .wb_lo_index_q,
  .wb_lo_data_q, .wb_hi_en_q, .wb_hi_index_q, .wb_hi_data_q);

// >>> uhm_core_model.sv
// register file model of the core that feeds the unit
`timescale 1ns/10ps
module uhm_core_model (
  // clock
  input  wire        sys_clk,
  // encoding under issue
  input  wire [31:0] instr,
  // writeback from the unit
  input  wire        lo_en,
  input  wire [3:0]  lo_idx,
  input  wire [31:0] lo_data,
  input  wire        hi_en,
  input  wire [3:0]  hi_idx,
  input  wire [31:0] hi_data,
  // operands read at the encoded indices
  output wire [31:0] n_data,
  output wire [31:0] m_data,
  output wire [31:0] h_data,
  output wire [31:0] l_data
);
  logic [31:0] regs [0:15];
  assign n_data = regs[instr[19:16]];
  assign m_data = regs[instr[3:0]];
  assign h_data = regs[instr[11:8]];
  assign l_data = regs[instr[15:12]];
  always @(posedge sys_clk) begin
    if (lo_en) regs[lo_idx] <= lo_data;
    if (hi_en) regs[hi_idx] <= hi_data;
  end
endmodule

// >>> uhm_exec_test.sv
// self-checking testbench for the halving subtract and long multiply unit
`timescale 1ns/10ps
`include "uhm_defs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module uhm_exec_test;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        issue_valid = 1'b0;
  logic [31:0] issue_instr = 32'h0;
  logic        issue_cond_pass = 1'b0;
  logic        dsp_on = 1'b1;
  logic        main_on = 1'b1;
  wire  [31:0] n_d, m_d, h_d, l_d, wb_lo_data_q, wb_hi_data_q;
  wire  [3:0]  wb_lo_index_q, wb_hi_index_q;
  wire         done_q, undef_q, unpred_q, flags_we_q, wb_lo_en_q, wb_hi_en_q;
  integer      err_total = 0;
  integer      checks_done = 0;
  integer      cyc = 0;
  logic [2:0]  sts;
  always #50 sys_clk = ~sys_clk;
  uhm_exec dut_u (.sys_clk, .rstn, .issue_valid, .issue_instr,
    .issue_cond_pass, .signal_processing_extension_present(dsp_on),
    .main_extension_present(main_on), .first_source_data(n_d),
    .second_source_data(m_d), .high_dest_data(h_d), .low_dest_data(l_d),
    .done_q, .undef_q, .unpred_q, .flags_we_q, .wb_lo_en_q, .wb_lo_index_q,
    .wb_lo_data_q, .wb_hi_en_q, .wb_hi_index_q, .wb_hi_data_q);
  uhm_core_model core_u (.sys_clk, .instr(issue_instr), .lo_en(wb_lo_en_q),
    .lo_idx(wb_lo_index_q), .lo_data(wb_lo_data_q), .hi_en(wb_hi_en_q),
    .hi_idx(wb_hi_index_q), .hi_data(wb_hi_data_q), .n_data(n_d),
    .m_data(m_d), .h_data(h_d), .l_data(l_d));
  // ==========================================================
  // shared tasks
  function [31:0] enc(input [11:0] p, input [3:0] n, l, h, s, m);
    enc = {p, n, l, h, s, m};
  endfunction
  task iss(input [31:0] ins, input logic c);
    @(posedge sys_clk);
    issue_instr <= ins;
    issue_valid <= 1'b1;
    issue_cond_pass <= c;
    @(posedge sys_clk);
    issue_valid <= 1'b0;
    #1 sts = {done_q, undef_q, unpred_q};
    @(posedge sys_clk);
    #1;
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task t_halving;
    logic [31:0] n, m, e;
    logic [16:0] a, b;
    logic [8:0]  q;
    integer      k, j;
    n = 32'h1234_8000;
    m = 32'h5678_0001;
    core_u.regs[1] = n;
    core_u.regs[2] = m;
    for (k = 0; k < 3; k++) begin
      iss(enc(k == 0 ? `UHM_PFX_HSAX : k == 1 ? `UHM_PFX_HSUB16 :
        `UHM_PFX_HSUB8, 4'h1, 4'hf, 4'h3, 4'h6, 4'h2), 1'b1);
      a = {1'b0, n[15:0]} + {1'b0, m[31:16]};
      b = {1'b0, n[31:16]} - {1'b0, m[15:0]};
      if (k == 1) begin
        a = {1'b0, n[15:0]} - {1'b0, m[15:0]};
        b = {1'b0, n[31:16]} - {1'b0, m[31:16]};
      end
      e = {b[16:1], a[16:1]};
      for (j = 0; j < 4 && k == 2; j++) begin
        q = {1'b0, n[8*j +: 8]} - {1'b0, m[8*j +: 8]};
        e[8*j +: 8] = q[8:1];
      end
      `CHK(sts, 3'b100)
      `CHK(core_u.regs[3], e)
    end
    $display("halving test done");
  endtask
  task t_long;
    logic [63:0] p, e;
    integer      k;
    for (k = 0; k < 3; k++) begin
      core_u.regs[4] = 32'hffff_ffff;
      core_u.regs[5] = 32'hffff_fffe;
      core_u.regs[6] = 32'hffff_ffff;
      core_u.regs[7] = 32'h8000_0001;
      p = 64'hffff_ffff * 64'hffff_fffe;
      e = k == 0 ? p : k == 1 ? p + 64'hffff_ffff + 64'h8000_0001
        : p + 64'h8000_0001_ffff_ffff;
      iss(enc(k == 0 ? `UHM_PFX_MULL : `UHM_PFX_MDAL, 4'h4, 4'h6, 4'h7,
        k == 1 ? 4'h6 : 4'h0, 4'h5), 1'b1);
      `CHK(sts, 3'b100)
      `CHK({core_u.regs[7], core_u.regs[6]}, e)
    end
    $display("long multiply test done");
  endtask
  task t_refuse;
    logic [31:0] ins;
    integer      k;
    for (k = 0; k < 10; k++) begin
      case (k)
        0, 1: ins = enc(`UHM_PFX_HSUB16, 4'h1, 4'hf, 4'h3, 4'h6, 4'h2);
        2: ins = enc(`UHM_PFX_MDAL, 4'h4, 4'h6, 4'h7, 4'h6, 4'h5);
        3: ins = enc(`UHM_PFX_MULL, 4'h4, 4'h6, 4'h7, 4'h0, 4'h5);
        4: ins = enc(`UHM_PFX_MDAL, 4'h4, 4'h6, 4'h7, 4'h0, 4'h5);
        5: ins = enc(`UHM_PFX_HSAX, 4'hd, 4'hf, 4'h3, 4'h6, 4'h2);
        6: ins = enc(`UHM_PFX_HSUB8, 4'h1, 4'hf, 4'hf, 4'h6, 4'h2);
        7: ins = enc(`UHM_PFX_MULL, 4'h4, 4'h7, 4'h7, 4'h0, 4'h5);
        8: ins = enc(`UHM_PFX_MDAL, 4'h4, 4'h6, 4'h7, 4'h0, 4'hd);
        default: ins = enc(`UHM_PFX_MDAL, 4'h4, 4'hf, 4'h7, 4'h6, 4'h5);
      endcase
      core_u.regs[3] = 32'h5a5a_a5a5;
      core_u.regs[6] = 32'h5a5a_a5a5;
      core_u.regs[7] = 32'h5a5a_a5a5;
      @(posedge sys_clk);
      dsp_on <= !(k == 1 || k == 2);
      main_on <= !(k == 3 || k == 4);
      iss(ins, k != 0);
      `CHK(sts, k == 0 ? 3'b100 : k < 5 ? 3'b110 : 3'b101)
      `CHK(core_u.regs[3], 32'h5a5a_a5a5)
      `CHK(core_u.regs[6], 32'h5a5a_a5a5)
      `CHK(core_u.regs[7], 32'h5a5a_a5a5)
    end
    $display("refusal test done");
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    t_halving();
    t_long();
    t_refuse();
    summarize();
  end
endmodule
